// ### srrl_pkg.sv
// Function
// - Return opcode (low bit shadow flag) pops stack, top value goes to PC.
// - Return leaves both program counter latch registers untouched.
// - Shadow flag 1 copies W, STATUS and bank-select shadows into them.
// - Shadow flag 0 leaves W, STATUS and bank-select unchanged.
// - Rotate left through carry: old bit 7 to carry, old carry to bit 0.
// - Destination 0 writes result to W, destination 1 back to the file.
// - Access bit 0 selects access bank, 1 uses bank-select register.
// - Extended set, access bit 0 and f at most 95 use indexed offset.
package srrl_pkg;
   // ======================================================
   // Register offsets
   localparam logic [7:0] SRRL_A_INSTR   = 8'h00;
   localparam logic [7:0] SRRL_A_CTRL    = 8'h04;
   localparam logic [7:0] SRRL_A_W       = 8'h08;
   localparam logic [7:0] SRRL_A_STATUS  = 8'h0c;
   localparam logic [7:0] SRRL_A_BANK    = 8'h10;
   localparam logic [7:0] SRRL_A_WSHD    = 8'h14;
   localparam logic [7:0] SRRL_A_SSHD    = 8'h18;
   localparam logic [7:0] SRRL_A_BSHD    = 8'h1c;
   localparam logic [7:0] SRRL_A_PC      = 8'h20;
   localparam logic [7:0] SRRL_A_STACK   = 8'h24;
   localparam logic [7:0] SRRL_A_PCLAT   = 8'h28;
   localparam logic [7:0] SRRL_A_FSR2    = 8'h2c;
   localparam logic [7:0] SRRL_A_FADDR   = 8'h30;
   localparam logic [7:0] SRRL_A_FDATA   = 8'h34;
   localparam logic [7:0] SRRL_A_STAT    = 8'h38;
   // ======================================================
   // Field positions
   localparam int SRRL_C = 0;
   localparam int SRRL_Z = 2;
   localparam int SRRL_N = 4;
   localparam int SRRL_EXT_EN   = 0;
   localparam int SRRL_ST_BUSY  = 0;
   localparam int SRRL_ST_ILLEG = 1;
   // ======================================================
   // Reset values and opcodes
   localparam logic [7:0]  SRRL_RST_BYTE  = 8'h00;
   localparam logic [20:0] SRRL_RST_PC    = 21'h000000;
   localparam logic [11:0] SRRL_RST_ADDR  = 12'h000;
   localparam logic [14:0] SRRL_OP_RETURN = 15'h0009;
   localparam logic [5:0]  SRRL_OP_ROTL   = 6'h0d;
   localparam logic [7:0]  SRRL_IDX_LIMIT = 8'h5f;
   localparam logic [3:0]  SRRL_BANK_LO   = 4'h0;
   localparam logic [3:0]  SRRL_BANK_HI   = 4'hf;

   typedef struct packed {
      logic        we;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } srrl_mem_req_t;
endpackage : srrl_pkg

// ### srrl_file_mem.sv
`timescale 1ns/1ns
module srrl_file_mem
   import srrl_pkg::*;
#(
   parameter int DEPTH = 4096
) (
   // Clock
   input  wire logic          pclk,
   // Access
   input  wire srrl_mem_req_t req,
   output logic [7:0]         rdata
);
   logic [7:0] mem [DEPTH];

   // Read data comes from a register: one cycle latency
   always_ff @(posedge pclk) begin
      if (req.we) begin
         mem[req.addr] <= req.wdata;
      end
      rdata <= mem[req.addr];
   end
endmodule : srrl_file_mem

// ### srrl_core.sv
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module srrl_core
   import srrl_pkg::*;
#(
   parameter int STACK_DEPTH = 31,
   parameter int MEM_DEPTH   = 4096
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr
);
   typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_ROT, ST_RET, ST_RET2}
      srrl_state_t;

   srrl_state_t   state;
   logic [15:0]   ir;
   logic [7:0]    w, status, working_shadow_reg, status_shadow_reg, fsr2_l;
   logic [3:0]    bank_select_reg, bank_select_shadow_reg, fsr2_h;
   logic [20:0]   pc;
   logic [4:0]    pc_upper_latch;
   logic [7:0]    pc_high_latch;
   logic          ext_en, illegal, acc_done;
   logic [11:0]   faddr;
   logic [20:0]   stack [STACK_DEPTH];
   logic [4:0]    sp;
   logic [20:0]   top_of_return_stack;
   logic [7:0]    mem_rdata, next_res;
   logic [11:0]   core_addr;
   logic          mapped, fire, wr, start, is_ret, is_rot;
   srrl_mem_req_t mem_req;

   // ======================================================
   // APB handshake: one wait state, stalls while busy
   assign fire  = psel & penable & pready;
   assign wr    = fire & pwrite;
   assign start = wr && paddr == SRRL_A_INSTR;
   assign pready = acc_done;
   assign pslverr = pready & ~mapped;

   always_comb begin
      mapped = 1'b1;
      unique case (paddr)
         SRRL_A_INSTR, SRRL_A_CTRL, SRRL_A_W, SRRL_A_STATUS, SRRL_A_BANK,
         SRRL_A_WSHD, SRRL_A_SSHD, SRRL_A_BSHD, SRRL_A_PC, SRRL_A_STACK,
         SRRL_A_PCLAT, SRRL_A_FSR2, SRRL_A_FADDR, SRRL_A_FDATA,
         SRRL_A_STAT: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_done <= 1'b0;
      end else begin
         acc_done <= psel & penable & ~acc_done & (state == ST_IDLE);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel & penable & ~acc_done) begin
         unique case (paddr)
            SRRL_A_INSTR:   prdata <= {16'h0000, ir};
            SRRL_A_CTRL:    prdata <= {31'h00000000, ext_en};
            SRRL_A_W:       prdata <= {24'h000000, w};
            SRRL_A_STATUS:  prdata <= {24'h000000, status};
            SRRL_A_BANK:    prdata <= {28'h0000000, bank_select_reg};
            SRRL_A_WSHD:    prdata <= {24'h000000, working_shadow_reg};
            SRRL_A_SSHD:    prdata <= {24'h000000, status_shadow_reg};
            SRRL_A_BSHD:    prdata <= {28'h0000000, bank_select_shadow_reg};
            SRRL_A_PC:      prdata <= {11'h000, pc};
            SRRL_A_STACK:   prdata <= {11'h000, top_of_return_stack};
            SRRL_A_PCLAT:   prdata <= {19'h00000, pc_upper_latch,
                                       pc_high_latch};
            SRRL_A_FSR2:    prdata <= {20'h00000, fsr2_h, fsr2_l};
            SRRL_A_FADDR:   prdata <= {20'h00000, faddr};
            SRRL_A_FDATA:   prdata <= {24'h000000, mem_rdata};
            SRRL_A_STAT:    prdata <= {19'h00000, sp, 6'h00, illegal,
                                       state != ST_IDLE};
            default:        prdata <= 32'h00000000;
         endcase
      end
   end

   // ======================================================
   // Decode and sequencing
   assign is_ret = pwdata[15:1] == SRRL_OP_RETURN;
   assign is_rot = pwdata[15:10] == SRRL_OP_ROTL;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         ir    <= 16'h0000;
      end else begin
         unique case (state)
            ST_IDLE: if (start) begin
               ir <= pwdata[15:0];
               if (is_ret) state <= ST_RET;
               else if (is_rot) state <= ST_READ;
            end
            ST_READ: state <= ST_ROT;
            ST_ROT:  state <= ST_IDLE;
            ST_RET:  state <= ST_RET2;
            ST_RET2: state <= ST_IDLE;
         endcase
      end
   end

   // Set wins over the software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         illegal <= 1'b0;
      end else if (start && !is_ret && !is_rot) begin
         illegal <= 1'b1;
      end else if (wr && paddr == SRRL_A_STAT && pwdata[SRRL_ST_ILLEG]) begin
         illegal <= 1'b0;
      end
   end

   // ======================================================
   // File operand addressing
   always_comb begin
      if (ir[8]) begin
         core_addr = {bank_select_reg, ir[7:0]};
      end else if (ext_en && ir[7:0] <= SRRL_IDX_LIMIT) begin
         // Index wraps within the 12-bit data space
         core_addr = 12'({fsr2_h, fsr2_l} + {4'h0, ir[7:0]});
      end else if (ir[7:0] > SRRL_IDX_LIMIT) begin
         core_addr = {SRRL_BANK_HI, ir[7:0]};
      end else begin
         core_addr = {SRRL_BANK_LO, ir[7:0]};
      end
   end

   assign next_res = {mem_rdata[6:0], status[SRRL_C]};

   // Core owns the port while busy; APB sees FADDR otherwise
   always_comb begin
      mem_req.addr  = (state == ST_IDLE) ? faddr : core_addr;
      mem_req.we    = (state == ST_ROT && ir[9]) ||
                      (wr && paddr == SRRL_A_FDATA);
      mem_req.wdata = (state == ST_ROT) ? next_res : pwdata[7:0];
   end

   srrl_file_mem #(.DEPTH(MEM_DEPTH)) u_mem (
      .pclk  (pclk),
      .req   (mem_req),
      .rdata (mem_rdata)
   );

   // ======================================================
   // Working, status and bank-select registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         w <= SRRL_RST_BYTE;
      end else if (state == ST_RET) begin
         if (ir[0]) w <= working_shadow_reg;
      end else if (state == ST_ROT) begin
         if (!ir[9]) w <= next_res;
      end else if (wr && paddr == SRRL_A_W) begin
         w <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= SRRL_RST_BYTE;
      end else if (state == ST_RET) begin
         if (ir[0]) status <= status_shadow_reg;
      end else if (state == ST_ROT) begin
         status[SRRL_C] <= mem_rdata[7];
         status[SRRL_N] <= next_res[7];
         status[SRRL_Z] <= next_res == 8'h00;
      end else if (wr && paddr == SRRL_A_STATUS) begin
         status <= {3'h0, pwdata[4:0]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank_select_reg <= 4'h0;
      end else if (state == ST_RET) begin
         if (ir[0]) bank_select_reg <= bank_select_shadow_reg;
      end else if (wr && paddr == SRRL_A_BANK) begin
         bank_select_reg <= pwdata[3:0];
      end
   end

   // Software-loaded configuration and shadows
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_en  <= 1'b0;
         working_shadow_reg     <= SRRL_RST_BYTE;
         status_shadow_reg      <= SRRL_RST_BYTE;
         bank_select_shadow_reg <= 4'h0;
         fsr2_l  <= SRRL_RST_BYTE;
         fsr2_h  <= 4'h0;
         faddr   <= SRRL_RST_ADDR;
         pc_upper_latch <= 5'h00;
         pc_high_latch  <= SRRL_RST_BYTE;
      end else if (wr) begin
         unique case (paddr)
            SRRL_A_CTRL:    ext_en  <= pwdata[SRRL_EXT_EN];
            SRRL_A_WSHD: working_shadow_reg <= pwdata[7:0];
            SRRL_A_SSHD: status_shadow_reg  <= {3'h0, pwdata[4:0]};
            SRRL_A_BSHD: bank_select_shadow_reg <= pwdata[3:0];
            SRRL_A_FSR2:    {fsr2_h, fsr2_l} <= pwdata[11:0];
            SRRL_A_FADDR:   faddr   <= pwdata[11:0];
            SRRL_A_PCLAT:   {pc_upper_latch, pc_high_latch} <= pwdata[12:0];
            default: ;
         endcase
      end
   end

   // ======================================================
   // Return stack; popping an empty stack yields zero
   assign top_of_return_stack = (sp == 5'd0) ? SRRL_RST_PC : stack[sp - 5'd1];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp <= 5'd0;
         pc <= SRRL_RST_PC;
      end else if (state == ST_RET) begin
         pc <= top_of_return_stack;
         if (sp != 5'd0) sp <= sp - 5'd1;
      end else if (wr && paddr == SRRL_A_STACK &&
                   sp != 5'(STACK_DEPTH)) begin
         sp <= sp + 5'd1;
      end
   end

   // A full stack silently drops a push
   always_ff @(posedge pclk) begin
      if (state == ST_IDLE && wr && paddr == SRRL_A_STACK &&
          sp != 5'(STACK_DEPTH)) begin
         stack[sp] <= pwdata[20:0];
      end
   end

   // ======================================================
   // Checks
   property p_ret_pc;
      @(posedge pclk) disable iff (!presetn)
      state == ST_RET |=> pc == $past(top_of_return_stack);
   endproperty
   a_ret_pc: assert property (p_ret_pc) else $error("pc not popped");

   property p_ret_latch;
      @(posedge pclk) disable iff (!presetn)
      state == ST_RET |=> $stable(pc_upper_latch) && $stable(pc_high_latch)
                          ##1 state == ST_IDLE;
   endproperty
   a_ret_latch: assert property (p_ret_latch)
      else $error("latch changed on return");

   property p_ret_shadow;
      @(posedge pclk) disable iff (!presetn)
      state == ST_RET && ir[0] |=> w == $past(working_shadow_reg) &&
         status == $past(status_shadow_reg) &&
         bank_select_reg == $past(bank_select_shadow_reg);
   endproperty
   a_ret_shadow: assert property (p_ret_shadow)
      else $error("shadow not restored");

   property p_ret_keep;
      @(posedge pclk) disable iff (!presetn)
      state == ST_RET && !ir[0] |=> $stable(w) && $stable(status) &&
                                    $stable(bank_select_reg);
   endproperty
   a_ret_keep: assert property (p_ret_keep)
      else $error("return altered registers");

   property p_rot_carry;
      @(posedge pclk) disable iff (!presetn)
      state == ST_READ ##1 state == ST_ROT |=>
         status[SRRL_C] == $past(mem_rdata[7]);
   endproperty
   a_rot_carry: assert property (p_rot_carry)
      else $error("carry wrong");

   property p_rot_w;
      @(posedge pclk) disable iff (!presetn)
      state == ST_ROT && !ir[9] |=>
         w == {$past(mem_rdata[6:0]), $past(status[SRRL_C])};
   endproperty
   a_rot_w: assert property (p_rot_w) else $error("W result wrong");

   property p_rot_file;
      @(posedge pclk) disable iff (!presetn)
      state == ST_ROT |-> mem_req.we == ir[9] &&
         mem_req.wdata == {mem_rdata[6:0], status[SRRL_C]};
   endproperty
   a_rot_file: assert property (p_rot_file)
      else $error("file write-back wrong");

   property p_bank;
      @(posedge pclk) disable iff (!presetn)
      state == ST_READ && ir[8] |-> mem_req.addr == {bank_select_reg, ir[7:0]};
   endproperty
   a_bank: assert property (p_bank) else $error("bank address wrong");

   property p_indexed;
      @(posedge pclk) disable iff (!presetn)
      state == ST_READ && !ir[8] && ext_en && ir[7:0] <= 8'h5f |->
         mem_req.addr == 12'({fsr2_h, fsr2_l} + {4'h0, ir[7:0]});
   endproperty
   a_indexed: assert property (p_indexed)
      else $error("indexed address wrong");

   property p_flags;
      @(posedge pclk) disable iff (!presetn)
      state == ST_ROT |=> status[SRRL_Z] == ($past(next_res) == 8'h00) &&
                          status[SRRL_N] == $past(next_res[7]);
   endproperty
   a_flags: assert property (p_flags) else $error("N or Z wrong");

   c_ret_s: cover property (@(posedge pclk) state == ST_RET && ir[0]);
   c_rot_w: cover property (@(posedge pclk) state == ST_ROT && !ir[9]);
   c_rot_x: cover property (@(posedge pclk)
      state == ST_READ && !ir[8] && ext_en && ir[7:0] <= 8'h5f);
endmodule : srrl_core

// ### tb_top.sv
`timescale 1ns/1ns
module tb_top
   import srrl_pkg::*;
;
   // ======================================================
   // Clock, reset and bus signals
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   int          err_total;
   int          checks;
   int          cyc;

   srrl_core i_dut (
      .pclk    (pclk),
      .presetn (presetn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .pready  (pready),
      .prdata  (prdata),
      .pslverr (pslverr)
   );

   initial pclk = 1'b0;
   always #50 pclk = ~pclk;

   // ======================================================
   // Reporting
   task automatic report_and_stop;
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop

   // Whole run needs well under a thousand cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // ======================================================
   // APB master
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Sampled values here are those seen by the slave at this edge
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp);
   endtask : rd_chk

   task automatic mem_wr(input logic [11:0] a, input logic [7:0] d);
      wr(SRRL_A_FADDR, {20'h0, a});
      wr(SRRL_A_FDATA, {24'h0, d});
   endtask : mem_wr

   task automatic mem_chk(input logic [11:0] a, input logic [7:0] d);
      wr(SRRL_A_FADDR, {20'h0, a});
      rd_chk(SRRL_A_FDATA, {24'h0, d});
   endtask : mem_chk

   // ======================================================
   // Scenarios
   task automatic t_return_plain;
      wr(SRRL_A_STACK, 32'h01234);
      wr(SRRL_A_STACK, 32'h05678);
      wr(SRRL_A_W, 32'ha5);
      wr(SRRL_A_STATUS, 32'h11);
      wr(SRRL_A_BANK, 32'h3);
      wr(SRRL_A_WSHD, 32'h5a);
      wr(SRRL_A_SSHD, 32'h04);
      wr(SRRL_A_BSHD, 32'hc);
      wr(SRRL_A_PCLAT, 32'h1f55);
      wr(SRRL_A_INSTR, 32'h0012);
      rd_chk(SRRL_A_PC, 32'h05678);
      rd_chk(SRRL_A_STACK, 32'h01234);
      rd_chk(SRRL_A_W, 32'ha5);
      rd_chk(SRRL_A_STATUS, 32'h11);
      rd_chk(SRRL_A_BANK, 32'h3);
      rd_chk(SRRL_A_PCLAT, 32'h1f55);
      $display("done t_return_plain");
   endtask : t_return_plain

   task automatic t_return_shadow;
      wr(SRRL_A_INSTR, 32'h0013);
      rd_chk(SRRL_A_PC, 32'h01234);
      rd_chk(SRRL_A_W, 32'h5a);
      rd_chk(SRRL_A_STATUS, 32'h04);
      rd_chk(SRRL_A_BANK, 32'hc);
      rd_chk(SRRL_A_PCLAT, 32'h1f55);
      $display("done t_return_shadow");
   endtask : t_return_shadow

   task automatic t_rotate_to_w;
      wr(SRRL_A_BANK, 32'h2);
      mem_wr(12'h234, 8'he6);
      wr(SRRL_A_STATUS, 32'h00);
      wr(SRRL_A_INSTR, 32'h3534);
      rd_chk(SRRL_A_W, 32'hcc);
      rd_chk(SRRL_A_STATUS, 32'h11);
      mem_chk(12'h234, 8'he6);
      $display("done t_rotate_to_w");
   endtask : t_rotate_to_w

   task automatic t_rotate_access;
      mem_wr(12'hf80, 8'h80);
      wr(SRRL_A_STATUS, 32'h00);
      wr(SRRL_A_INSTR, 32'h3680);
      wr(SRRL_A_INSTR, 32'h3680);
      mem_chk(12'hf80, 8'h01);
      rd_chk(SRRL_A_STATUS, 32'h00);
      wr(SRRL_A_INSTR, 32'h3680);
      wr(SRRL_A_INSTR, 32'h3680);
      wr(SRRL_A_INSTR, 32'h3680);
      wr(SRRL_A_INSTR, 32'h3680);
      wr(SRRL_A_INSTR, 32'h3680);
      wr(SRRL_A_INSTR, 32'h3680);
      wr(SRRL_A_INSTR, 32'h3680);
      mem_chk(12'hf80, 8'h80);
      wr(SRRL_A_INSTR, 32'h3680);
      mem_chk(12'hf80, 8'h00);
      rd_chk(SRRL_A_STATUS, 32'h05);
      rd_chk(SRRL_A_W, 32'hcc);
      $display("done t_rotate_access");
   endtask : t_rotate_access

   task automatic t_rotate_indexed;
      wr(SRRL_A_CTRL, 32'h1);
      wr(SRRL_A_FSR2, 32'h100);
      mem_wr(12'h15f, 8'h41);
      mem_wr(12'h160, 8'h55);
      mem_wr(12'hf60, 8'h03);
      wr(SRRL_A_STATUS, 32'h00);
      wr(SRRL_A_INSTR, 32'h365f);
      mem_chk(12'h15f, 8'h82);
      rd_chk(SRRL_A_STATUS, 32'h10);
      wr(SRRL_A_INSTR, 32'h3660);
      mem_chk(12'hf60, 8'h06);
      mem_chk(12'h160, 8'h55);
      $display("done t_rotate_indexed");
   endtask : t_rotate_indexed

   task automatic t_unmapped;
      logic [31:0] r;
      logic        e;
      apb(1'b0, 8'h3c, 32'h0, r, e);
      chk(r, 32'h0);
      chk({31'h0, e}, 32'h1);
      // Unknown opcode sets the sticky flag; writing 1 clears it
      wr(SRRL_A_INSTR, 32'hffff);
      rd_chk(SRRL_A_STAT, 32'h2);
      wr(SRRL_A_STAT, 32'h2);
      rd_chk(SRRL_A_STAT, 32'h0);
      $display("done t_unmapped");
   endtask : t_unmapped

   // ======================================================
   // Main sequence
   initial begin
      err_total = 0;
      checks    = 0;
      cyc       = 0;
      presetn   = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 8'h00;
      pwdata    = 32'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_return_plain();
      t_return_shadow();
      t_rotate_to_w();
      t_rotate_access();
      t_rotate_indexed();
      t_unmapped();
      report_and_stop();
   end
endmodule : tb_top
